// file: occ_map.vh
/*
 * Register offsets, field positions and reset values of the oscillator
 * clock configuration register block.
 * Assumes inclusion by bare name from the design files of this folder.
 */
`ifndef OCC_MAP_VH
`define OCC_MAP_VH

// ------------------------------------------------------------
// Register addresses (word indices on the plain port)
// ------------------------------------------------------------
`define OCC_ADDR_W 2
`define OCC_ADDR_CTRL 2'h0
`define OCC_ADDR_DIV 2'h1
`define OCC_ADDR_FBD 2'h2
`define OCC_ADDR_TUN 2'h3

// ------------------------------------------------------------
// Oscillator control fields
// ------------------------------------------------------------
`define OCC_CUR_HI 14
`define OCC_CUR_LO 12
`define OCC_REQ_HI 10
`define OCC_REQ_LO 8
`define OCC_FREEZE_BIT 7
`define OCC_PLL_LOCK_BIT 5
`define OCC_FAIL_BIT 3
`define OCC_SEC_EN_BIT 1
`define OCC_SWITCH_BIT 0

// ------------------------------------------------------------
// Clock divisor, feedback and trim fields
// ------------------------------------------------------------
`define OCC_ROI_BIT 15
`define OCC_DOZE_HI 14
`define OCC_DOZE_LO 12
`define OCC_DOZE_ENABLE_BIT 11
`define OCC_FRCDIV_HI 10
`define OCC_FRCDIV_LO 8
`define OCC_POST_HI 7
`define OCC_POST_LO 6
`define OCC_PRE_HI 4
`define OCC_PRE_LO 0
`define OCC_FBD_HI 8
`define OCC_FBD_LO 0
`define OCC_TUN_HI 5
`define OCC_TUN_LO 0

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define OCC_DOZE_RST 3'h3
`define OCC_FRCDIV_RST 3'h0
`define OCC_POST_RST 2'h1
`define OCC_POST_RSVD 2'h2
`define OCC_PRE_RST 5'h00
`define OCC_FBD_RST 9'h030
`define OCC_TUN_RST 6'h00
`define OCC_FRCDIV_MAX 3'h7
`define OCC_FRCDIV_MAX_LOG 4'h8
`define OCC_SETTLE_CYC 4'ha

`endif

// file: occ_divider.v
/*
 * Power-of-two enable divider: emits a one-cycle pulse every 2**shift
 * cycles of the enable input.
 * Assumes a single system clock and synchronous active-low reset.
 */
module occ_divider #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // Control
  input wire tick_in,
  input wire [3:0] shift_in,
  // Result
  output reg pulse_out
);
  reg [W-1:0] count;
  wire [W:0] span;

  assign span = {{W{1'b0}}, 1'b1} << shift_in;

  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      count <= {W{1'b0}};
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= 1'b0;
      if (tick_in) begin
        if ({1'b0, count} >= span - {{W{1'b0}}, 1'b1}) begin
          count <= {W{1'b0}};
          pulse_out <= 1'b1;
        end else begin
          count <= count + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// file: occ_regs.v
/*
 * Oscillator clock configuration registers: control, divisor, PLL
 * feedback and fast RC trim, with the switch handshake and doze and
 * fast RC postscaler enables derived from the oscillator tick.
 * Assumes inputs synchronous to clk_sys_in, configuration straps stable
 * at reset release, and an external sequencer that performs the switch.
 */
//
// Behaviour
// - Active source code reads read-only at bits 14-12, eight source codes.
// - Requested source code is writable at bits 10-8, same encoding.
// - Both source fields load from configuration straps on the first edge after reset.
// - Freeze bit 7 with switch mode strap 1 locks the source request, switch and PLL settings.
// - PLL lock bit 5 reads the PLL lock input directly.
// - Fail flag bit 3 set by fail monitor, software clears only.
// - Bit 1 enables the secondary oscillator.
// - Switch request bit 0 starts a switch, clears when switch completes.
// - Unimplemented bits read zero.
// - Recover on interrupt bit 15 lets interrupts clear doze enable.
// - Doze ratio bits 14-12 divide by 2**code, reset code 3.
// - Doze enable bit 11 applies the ratio, else ratio is 1:1.
// - Fast RC postscaler bits 10-8 divide 2**code, 7 gives 256.
// - PLL postscaler bits 7-6: 2, 4 default, reserved, 8.
// - PLL prescaler bits 4-0 divide by code plus two.
// - Feedback multiplier bits 8-0 multiply by code plus two, default 50.
// - Fast RC trim is a signed six-bit offset.
// - Instruction clock is oscillator clock divided by two.
`include "occ_map.vh"

module occ_regs (
  // Clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // Register port
  input wire [`OCC_ADDR_W-1:0] addr_in,
  input wire [15:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [15:0] rdata_out,
  // Configuration straps
  input wire [2:0] cfg_source_in,
  input wire clock_switch_mode_cfg_in,
  input wire unlock_in,
  // Oscillator status
  input wire pll_locked_in,
  input wire failsafe_monitor_fail_in,
  input wire switch_done_in,
  input wire interrupt_in,
  input wire osc_tick_in,
  // Oscillator controls
  output reg [2:0] active_source_sel_out,
  output reg [2:0] requested_source_sel_out,
  output reg switch_request_out,
  output reg secondary_osc_enable_out,
  output reg config_locked_out,
  output reg [1:0] pll_postscaler_out,
  output reg [4:0] pll_prescaler_out,
  output reg [8:0] pll_feedback_multiplier_out,
  output reg [5:0] fast_rc_trim_out,
  output reg instr_tick_out,
  output reg periph_tick_out,
  output reg cpu_tick_out,
  output reg frc_tick_out
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_SETTLE = 3'b100;

  reg [2:0] state;
  reg [3:0] settle;
  reg [2:0] active_source_sel;
  reg [2:0] requested_source_sel;
  reg config_freeze_bit;
  reg clock_fail_flag;
  reg secondary_osc_enable;
  reg switch_request_bit;
  reg recover_on_interrupt;
  reg [2:0] doze_ratio;
  reg doze_enable;
  reg [2:0] fast_rc_postscaler;
  reg [1:0] pll_postscaler;
  reg [4:0] pll_prescaler;
  reg [8:0] pll_feedback_multiplier;
  reg [5:0] fast_rc_trim;
  reg cfg_loaded;
  reg half;
  reg [15:0] next_rdata;
  wire locked;
  wire wr_ctrl;
  wire cpu_pulse;
  wire frc_pulse;
  wire [3:0] frc_shift;
  wire [3:0] doze_shift;
  wire instr_pulse;
  wire wr_div;
  wire wr_fbd;
  wire wr_tun;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function [3:0] frc_log2;
    input [2:0] code;
    begin
      if (code == `OCC_FRCDIV_MAX)
        frc_log2 = `OCC_FRCDIV_MAX_LOG;
      else
        frc_log2 = {1'b0, code};
    end
  endfunction

  // Write strobe qualified by one register index
  function wr_hit;
    input wr;
    input [`OCC_ADDR_W-1:0] addr;
    input [`OCC_ADDR_W-1:0] sel;
    begin
      wr_hit = wr && addr == sel;
    end
  endfunction

  // Freeze only bites when the switch mode strap allows it
  assign locked = config_freeze_bit & clock_switch_mode_cfg_in;
  assign wr_ctrl = wr_hit(wr_in, addr_in, `OCC_ADDR_CTRL) && unlock_in;
  assign wr_div = wr_hit(wr_in, addr_in, `OCC_ADDR_DIV);
  assign wr_fbd = wr_hit(wr_in, addr_in, `OCC_ADDR_FBD);
  assign wr_tun = wr_hit(wr_in, addr_in, `OCC_ADDR_TUN);
  assign instr_pulse = osc_tick_in & half;
  assign frc_shift = frc_log2(fast_rc_postscaler);
  // Doze off runs the processor at the instruction rate
  assign doze_shift = doze_enable ? {1'b0, doze_ratio} : 4'h0;

  // ------------------------------------------------------------
  // Control register and switch handshake
  // ------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      settle <= 4'h0;
      active_source_sel <= 3'h0;
      requested_source_sel <= 3'h0;
      cfg_loaded <= 1'b0;
      config_freeze_bit <= 1'b0;
      clock_fail_flag <= 1'b0;
      secondary_osc_enable <= 1'b0;
      switch_request_bit <= 1'b0;
    end else begin
      // Straps are taken once, on the first edge after reset
      if (!cfg_loaded) begin
        cfg_loaded <= 1'b1;
        active_source_sel <= cfg_source_in;
        requested_source_sel <= cfg_source_in;
      end else if (wr_ctrl) begin
        config_freeze_bit <= wdata_in[`OCC_FREEZE_BIT];
        secondary_osc_enable <= wdata_in[`OCC_SEC_EN_BIT];
        if (!locked && state == ST_IDLE)
          requested_source_sel <= wdata_in[`OCC_REQ_HI:`OCC_REQ_LO];
      end
      // Monitor set wins over software clear
      if (failsafe_monitor_fail_in)
        clock_fail_flag <= 1'b1;
      else if (wr_ctrl && !wdata_in[`OCC_FAIL_BIT])
        clock_fail_flag <= 1'b0;
      case (state)
        ST_IDLE: begin
          // A request for the running source is aborted at once
          if (cfg_loaded && wr_ctrl && !locked && wdata_in[`OCC_SWITCH_BIT]) begin
            if (wdata_in[`OCC_REQ_HI:`OCC_REQ_LO] == active_source_sel) begin
              switch_request_bit <= 1'b0;
            end else begin
              switch_request_bit <= 1'b1;
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // The external sequencer reports the new clock running
          if (switch_done_in) begin
            settle <= 4'h0;
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // The new source runs the settle count of ticks before handover
          if (osc_tick_in) begin
            if (settle == `OCC_SETTLE_CYC - 4'h1) begin
              active_source_sel <= requested_source_sel;
              switch_request_bit <= 1'b0;
              state <= ST_IDLE;
            end else begin
              settle <= settle + 4'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Divisor, feedback and trim registers
  // ------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      recover_on_interrupt <= 1'b0;
      doze_ratio <= `OCC_DOZE_RST;
      doze_enable <= 1'b0;
      fast_rc_postscaler <= `OCC_FRCDIV_RST;
      pll_postscaler <= `OCC_POST_RST;
      pll_prescaler <= `OCC_PRE_RST;
      pll_feedback_multiplier <= `OCC_FBD_RST;
      fast_rc_trim <= `OCC_TUN_RST;
    end else begin
      if (wr_div) begin
        recover_on_interrupt <= wdata_in[`OCC_ROI_BIT];
        doze_ratio <= wdata_in[`OCC_DOZE_HI:`OCC_DOZE_LO];
        fast_rc_postscaler <= wdata_in[`OCC_FRCDIV_HI:`OCC_FRCDIV_LO];
        if (!locked) begin
          // Reserved postscaler code is refused
          if (wdata_in[`OCC_POST_HI:`OCC_POST_LO] != `OCC_POST_RSVD)
            pll_postscaler <= wdata_in[`OCC_POST_HI:`OCC_POST_LO];
          pll_prescaler <= wdata_in[`OCC_PRE_HI:`OCC_PRE_LO];
        end
      end
      // Interrupt recovery wins over a concurrent write
      if (recover_on_interrupt && interrupt_in)
        doze_enable <= 1'b0;
      else if (wr_div)
        doze_enable <= wdata_in[`OCC_DOZE_ENABLE_BIT];
      if (wr_fbd && !locked)
        pll_feedback_multiplier <= wdata_in[`OCC_FBD_HI:`OCC_FBD_LO];
      if (wr_tun)
        fast_rc_trim <= wdata_in[`OCC_TUN_HI:`OCC_TUN_LO];
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always @* begin
    next_rdata = 16'h0000;
    case (addr_in)
      `OCC_ADDR_CTRL: begin
        next_rdata[`OCC_CUR_HI:`OCC_CUR_LO] = active_source_sel;
        next_rdata[`OCC_REQ_HI:`OCC_REQ_LO] = requested_source_sel;
        next_rdata[`OCC_FREEZE_BIT] = config_freeze_bit;
        next_rdata[`OCC_PLL_LOCK_BIT] = pll_locked_in;
        next_rdata[`OCC_FAIL_BIT] = clock_fail_flag;
        next_rdata[`OCC_SEC_EN_BIT] = secondary_osc_enable;
        next_rdata[`OCC_SWITCH_BIT] = switch_request_bit;
      end
      `OCC_ADDR_DIV: begin
        next_rdata[`OCC_ROI_BIT] = recover_on_interrupt;
        next_rdata[`OCC_DOZE_HI:`OCC_DOZE_LO] = doze_ratio;
        next_rdata[`OCC_DOZE_ENABLE_BIT] = doze_enable;
        next_rdata[`OCC_FRCDIV_HI:`OCC_FRCDIV_LO] = fast_rc_postscaler;
        next_rdata[`OCC_POST_HI:`OCC_POST_LO] = pll_postscaler;
        next_rdata[`OCC_PRE_HI:`OCC_PRE_LO] = pll_prescaler;
      end
      `OCC_ADDR_FBD: begin
        next_rdata[`OCC_FBD_HI:`OCC_FBD_LO] = pll_feedback_multiplier;
      end
      `OCC_ADDR_TUN: begin
        next_rdata[`OCC_TUN_HI:`OCC_TUN_LO] = fast_rc_trim;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Clock enables
  // ------------------------------------------------------------
  occ_divider #(
    .W(8)
  ) u_cpu_div (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .tick_in(instr_pulse),
    .shift_in(doze_shift),
    .pulse_out(cpu_pulse)
  );

  occ_divider #(
    .W(8)
  ) u_frc_div (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .tick_in(osc_tick_in),
    .shift_in(frc_shift),
    .pulse_out(frc_pulse)
  );

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------

  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      half <= 1'b0;
      rdata_out <= 16'h0000;
      active_source_sel_out <= 3'h0;
      requested_source_sel_out <= 3'h0;
      switch_request_out <= 1'b0;
      secondary_osc_enable_out <= 1'b0;
      config_locked_out <= 1'b0;
      pll_postscaler_out <= `OCC_POST_RST;
      pll_prescaler_out <= `OCC_PRE_RST;
      pll_feedback_multiplier_out <= `OCC_FBD_RST;
      fast_rc_trim_out <= `OCC_TUN_RST;
      instr_tick_out <= 1'b0;
      periph_tick_out <= 1'b0;
      cpu_tick_out <= 1'b0;
      frc_tick_out <= 1'b0;
    end else begin
      if (osc_tick_in)
        half <= ~half;
      instr_tick_out <= instr_pulse;
      periph_tick_out <= instr_pulse;
      cpu_tick_out <= cpu_pulse;
      frc_tick_out <= frc_pulse;
      // Read data stand in the cycle after each read strobe cycle, zero otherwise
      rdata_out <= rd_in ? next_rdata : 16'h0000;
      active_source_sel_out <= active_source_sel;
      requested_source_sel_out <= requested_source_sel;
      switch_request_out <= switch_request_bit;
      secondary_osc_enable_out <= secondary_osc_enable;
      config_locked_out <= locked;
      pll_postscaler_out <= pll_postscaler;
      pll_prescaler_out <= pll_prescaler;
      pll_feedback_multiplier_out <= pll_feedback_multiplier;
      fast_rc_trim_out <= fast_rc_trim;
    end
  end
endmodule

// file: occ_regs_assertions.sv
/*
 * Port checker for the oscillator clock configuration registers.
 * Assumes it is bound to occ_regs and that the straps stay steady.
 */
module occ_regs_chk (
  // Clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // Register port
  input wire [1:0] addr_in,
  input wire [15:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [15:0] rdata_out,
  // Straps and status
  input wire clock_switch_mode_cfg_in,
  input wire pll_locked_in,
  // Oscillator controls
  input wire [2:0] active_source_sel_out,
  input wire [2:0] requested_source_sel_out,
  input wire switch_request_out,
  input wire config_locked_out,
  input wire [1:0] pll_postscaler_out,
  input wire [4:0] pll_prescaler_out,
  input wire [8:0] pll_feedback_multiplier_out,
  input wire [5:0] fast_rc_trim_out,
  input wire instr_tick_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  chk_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside a read");
  chk_ctrl_zero: assert property ($past(rd_in) && $past(addr_in) == 2'h0
    |-> {rdata_out[15], rdata_out[11], rdata_out[6], rdata_out[4], rdata_out[2]} == 5'h00)
    else $error("unused control bit reads one");
  chk_fbd_zero: assert property ($past(rd_in) && $past(addr_in) == 2'h2
    |-> rdata_out[15:9] == 7'h00)
    else $error("unused feedback bit reads one");
  chk_pll_bit: assert property ($past(rd_in) && $past(addr_in) == 2'h0
    |-> rdata_out[5] == $past(pll_locked_in))
    else $error("pll lock bit wrong");
  chk_act_change: assert property ($past(reset_n_in, 3) && $changed(active_source_sel_out)
    |-> $past(switch_request_out) && active_source_sel_out == $past(requested_source_sel_out))
    else $error("active source changed without a switch");
  chk_lock_mode: assert property ($rose(config_locked_out) |-> $past(clock_switch_mode_cfg_in))
    else $error("lock without switch mode strap");
  chk_lock_hold: assert property (config_locked_out && $past(config_locked_out, 2)
    |-> $stable(pll_feedback_multiplier_out) && $stable(pll_prescaler_out)
    && $stable(pll_postscaler_out) && $stable(requested_source_sel_out))
    else $error("locked field changed");
  chk_tun_write: assert property (wr_in && addr_in == 2'h3
    |-> ##2 fast_rc_trim_out == $past(wdata_in[5:0], 2))
    else $error("trim write not applied");
  chk_post_rsvd: assert property (pll_postscaler_out != 2'h2)
    else $error("reserved postscaler code taken");
  chk_instr_gap: assert property (instr_tick_out |=> !instr_tick_out)
    else $error("instruction tick too fast");
endmodule

bind occ_regs occ_regs_chk i_occ_regs_chk (.*);

// file: occ_regs_tb.sv
/*
 * Self-checking testbench for occ_regs.
 * Assumes the design, its map header and the checker in this folder.
 */
module occ_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [1:0] addr_in = 2'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic unlock_in = 1'b0;
  logic [2:0] cfg_source_in = 3'h5;
  logic clock_switch_mode_cfg_in = 1'b0;
  logic pll_locked_in = 1'b1;
  logic failsafe_monitor_fail_in = 1'b0;
  logic switch_done_in = 1'b0;
  logic interrupt_in = 1'b0;
  logic osc_tick_in = 1'b0;
  wire [15:0] rdata_out;
  wire [2:0] active_source_sel_out;
  wire [2:0] requested_source_sel_out;
  wire switch_request_out;
  wire secondary_osc_enable_out;
  wire config_locked_out;
  wire [1:0] pll_postscaler_out;
  wire [4:0] pll_prescaler_out;
  wire [8:0] pll_feedback_multiplier_out;
  wire [5:0] fast_rc_trim_out;
  wire instr_tick_out;
  wire periph_tick_out;
  wire cpu_tick_out;
  wire frc_tick_out;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int it_cnt;
  int pt_cnt;
  int ct_cnt;
  int ft_cnt;
  // Rows: address, write data, read-back value
  localparam logic [33:0] rows [8] = '{
    {2'h1, 16'h7b9f, 16'h7b5f}, {2'h1, 16'h00c0, 16'h00c0}, {2'h1, 16'h0000, 16'h0000},
    {2'h2, 16'hffff, 16'h01ff}, {2'h2, 16'h0030, 16'h0030}, {2'h3, 16'hffff, 16'h003f},
    {2'h3, 16'h0020, 16'h0020}, {2'h3, 16'h001f, 16'h001f}};

  occ_regs i_occ_regs (.*);

  always #5 clk_sys_in = ~clk_sys_in;

  // ----------------------------------------
  // Oscillator tick and run limit
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    osc_tick_in <= ~osc_tick_in;
    cyc <= cyc + 1;
  end
  always @(posedge clk_sys_in) begin
    if (cyc == 20000) begin
      error_cnt += 1;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count += 1;
    if (g !== e) begin
      error_cnt += 1;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d, input logic u);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    unlock_in <= u;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    unlock_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(negedge clk_sys_in);
    chk("rdata", e, rdata_out);
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys_in);
    case (k)
      0: failsafe_monitor_fail_in <= 1'b1;
      1: switch_done_in <= 1'b1;
      default: interrupt_in <= 1'b1;
    endcase
    @(posedge clk_sys_in);
    failsafe_monitor_fail_in <= 1'b0;
    switch_done_in <= 1'b0;
    interrupt_in <= 1'b0;
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(2'h0, 16'h5520);
    rd(2'h1, 16'h3040);
    rd(2'h2, 16'h0030);
    rd(2'h3, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i][33:32], rows[i][31:16], 1'b1);
      rd(rows[i][33:32], rows[i][15:0]);
    end
    wr(2'h0, 16'h0502, 1'b0);
    rd(2'h0, 16'h5520);
    wr(2'h0, 16'h050a, 1'b1);
    rd(2'h0, 16'h5522);
    chk("sec_en", 16'h0001, {15'h0, secondary_osc_enable_out});
    @(posedge clk_sys_in);
    pll_locked_in <= 1'b0;
    pulse(0);
    rd(2'h0, 16'h550a);
    wr(2'h0, 16'h0502, 1'b1);
    rd(2'h0, 16'h5502);
    for (int c = 0; c < 8; c++) begin
      wr(2'h0, {5'h00, c[2:0], 8'h02}, 1'b1);
      rd(2'h0, {4'h5, 1'b0, c[2:0], 8'h02});
    end
    wr(2'h0, 16'h0203, 1'b1);
    rd(2'h0, 16'h5203);
    chk("sw_req", 16'h0001, {15'h0, switch_request_out});
    pulse(1);
    for (int i = 0; i < 200 && switch_request_out !== 1'b0; i++) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk("active", 16'h0002, {13'h0, active_source_sel_out});
    rd(2'h0, 16'h2202);
    wr(2'h0, 16'h0203, 1'b1);
    repeat (3) @(posedge clk_sys_in);
    rd(2'h0, 16'h2202);
    wr(2'h1, 16'hb800, 1'b1);
    pulse(2);
    rd(2'h1, 16'hb000);
    wr(2'h1, 16'h3800, 1'b1);
    pulse(2);
    rd(2'h1, 16'h3800);
    it_cnt = 0;
    pt_cnt = 0;
    ct_cnt = 0;
    ft_cnt = 0;
    repeat (64) begin
      @(posedge clk_sys_in);
      it_cnt += instr_tick_out;
      pt_cnt += periph_tick_out;
      ct_cnt += cpu_tick_out;
      ft_cnt += frc_tick_out;
    end
    chk("instr_ticks", 16'd16, it_cnt[15:0]);
    chk("periph_ticks", 16'h0010, pt_cnt[15:0]);
    chk("cpu_ticks", 16'h0002, ct_cnt[15:0]);
    chk("frc_ticks", 16'd32, ft_cnt[15:0]);
    wr(2'h1, 16'h0700, 1'b1);
    repeat (4) @(posedge clk_sys_in);
    ct_cnt = 0;
    ft_cnt = 0;
    repeat (1024) begin
      @(posedge clk_sys_in);
      ct_cnt += cpu_tick_out;
      ft_cnt += frc_tick_out;
    end
    chk("cpu_ticks", 16'h0100, ct_cnt[15:0]);
    chk("frc_ticks", 16'h0002, ft_cnt[15:0]);
    wr(2'h0, 16'h0282, 1'b1);
    @(negedge clk_sys_in);
    chk("locked", 16'h0000, {15'h0, config_locked_out});
    @(posedge clk_sys_in);
    clock_switch_mode_cfg_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk("locked", 16'h0001, {15'h0, config_locked_out});
    rd(2'h0, 16'h2282);
    wr(2'h2, 16'h0040, 1'b1);
    rd(2'h2, 16'h0030);
    wr(2'h0, 16'h0183, 1'b1);
    rd(2'h0, 16'h2282);
    wr(2'h1, 16'h00c3, 1'b1);
    rd(2'h1, 16'h0000);
    wr(2'h3, 16'h0005, 1'b1);
    rd(2'h3, 16'h0005);
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(2'h0, 16'h5500);
    rd(2'h3, 16'h0000);
    wrap_up();
  end
endmodule
